// ===== hdl/p2p_pkg.sv
// constants, field layout, register map and timing for the power-to-pulse datapath
// assumes a single 100 MHz clock and an APB register port with 32-bit data
package p2p_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PULSE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_POWER = 8'h0C;
    localparam logic [7:0] OFS_CFCNT = 8'h10;

    // control register fields and reset value
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_OVR_BIT = 1;
    localparam int CTRL_S0_BIT = 2;
    localparam int CTRL_S1_BIT = 3;
    localparam int CTRL_SCF_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h01;

    // status register fields
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_REVERSE_POWER_FLAG_BIT = 1;
    localparam int STAT_SUPPLY_BIT = 2;

    // supply monitor: trip level and hysteresis in millivolts
    localparam logic [12:0] SUPPLY_TRIP_MV = 13'h0FA0;
    localparam logic [12:0] SUPPLY_HYST_MV = 13'h0064;
    localparam int SUPPLY_FILTER_US = 1000;
    localparam int SUPPLY_FILTER_CYCLES = SUPPLY_FILTER_US * CYC_PER_US;

    // output pulse width
    localparam int PULSE_WIDTH_US = 100;
    localparam int PULSE_CYCLES = PULSE_WIDTH_US * CYC_PER_US;

    // calibration multiple of the energy rate, as a power of two
    localparam logic [3:0] CF_MULT_MAX_LOG2 = 4'hB;
    localparam logic [3:0] CF_MULT_TOP_LOG2 = 4'h7;

    typedef enum logic [1:0] {
        SUP_OFF = 2'b00,
        SUP_RISE = 2'b01,
        SUP_ON = 2'b11,
        SUP_FALL = 2'b10
    } supply_state_t;

    // log2 of the calibration multiple for a scale select and rate select
    function automatic logic [3:0] cf_mult_log2(input logic calib_scale_select, input logic [1:0] sel);
        if (!calib_scale_select && sel == 2'b11) begin
            return CF_MULT_MAX_LOG2;
        end
        return CF_MULT_TOP_LOG2 - {2'b00, sel} - {3'b000, ~calib_scale_select};
    endfunction
endpackage

// ===== hdl/one_pole.sv
// first-order recursive low-pass section, y follows x with pole 1 - 2^-SHIFT
// assumes en marks one new sample; clr empties the state at once
`timescale 1ns/1ps
module one_pole #(
    parameter int W = 32,
    parameter int SHIFT = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic en,
    input wire logic clr,
    input wire logic signed [W-1:0] x,
    output logic signed [W-1:0] y
);
    localparam int AW = W + SHIFT;
    logic signed [AW-1:0] s_q;
    logic signed [AW-1:0] s_d;

    // leaky integrator; extra SHIFT bits keep the step free of truncation bias
    always_comb begin
        s_d = s_q + AW'(x) - (s_q >>> SHIFT);
    end

    always_ff @(posedge clk) begin
        if (srst || clr) begin
            s_q <= '0;
        end else if (en) begin
            s_q <= s_d;
        end
    end

    assign y = W'(s_q >>> SHIFT);
endmodule // one_pole

// ===== hdl/power_to_pulse_datapath.sv
// power-to-pulse datapath: dc removal, multiply, low-pass, digital-to-frequency
// assumes sample words arrive synchronous to CLK with a valid strobe and a
// digitised supply reading in millivolts; registers over APB, zero wait states
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module power_to_pulse_datapath
    import p2p_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int HPF_SHIFT = 8,
    parameter int LPF_SHIFT = 14,
    parameter int ACC_W = 48,
    parameter int E_SHIFT_BASE = 44,
    parameter int FILTER_CYCLES = SUPPLY_FILTER_CYCLES,
    parameter int PULSE_WIDTH = PULSE_CYCLES
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SAMPLE_VALID,
    input wire logic signed [SAMPLE_W-1:0] CURRENT_CHANNEL,
    input wire logic signed [SAMPLE_W-1:0] LINE_VOLTAGE_CHANNEL,
    input wire logic [12:0] SUPPLY_MV,
    input wire logic CALIB_SCALE_SELECT,
    input wire logic RATE_SELECT_LSB,
    input wire logic RATE_SELECT_MSB,
    output logic ENERGY_PULSE_A_N,
    output logic ENERGY_PULSE_B_N,
    output logic CALIB_PULSE_OUT_N,
    output logic REVERSE_POWER_FLAG
);
    localparam int PW = 2 * SAMPLE_W;
    localparam int FC_W = $clog2(FILTER_CYCLES + 1);

    supply_state_t sup_q;
    logic [FC_W-1:0] filt_cnt_q;
    logic [4:0] ctrl_q;
    logic [15:0] pulse_w_q;
    logic [31:0] cf_count_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic active;
    logic supply_ok;
    logic calib_scale_select;
    logic [1:0] sel;
    logic [5:0] e_shift;
    logic [5:0] cf_shift;
    logic signed [SAMPLE_W-1:0] i_lp;
    logic signed [SAMPLE_W-1:0] v_lp;
    logic signed [SAMPLE_W-1:0] i_hp_q;
    logic signed [SAMPLE_W-1:0] v_hp_q;
    logic hp_vld_q;
    logic signed [PW-1:0] prod_q;
    logic prod_vld_q;
    logic signed [PW-1:0] power;
    logic pow_vld_q;
    logic [PW-1:0] pow_mag;
    logic [ACC_W-1:0] e_acc_q;
    logic [ACC_W-1:0] cf_acc_q;
    logic [ACC_W-1:0] e_sum;
    logic [ACC_W-1:0] cf_sum;
    logic [ACC_W-1:0] e_thr;
    logic [ACC_W-1:0] cf_thr;
    logic e_fire;
    logic cf_fire;
    logic [15:0] ea_cnt_q;
    logic [15:0] eb_cnt_q;
    logic [15:0] cf_cnt_q;
    logic reverse_power_flag_q;
    logic wr_en;
    logic rd_setup;

    // supply monitor: level must hold for FILTER_CYCLES before the state flips
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sup_q <= SUP_OFF;
            filt_cnt_q <= '0;
        end else begin
            case (sup_q)
                SUP_OFF: begin
                    filt_cnt_q <= '0;
                    if (SUPPLY_MV >= SUPPLY_TRIP_MV + SUPPLY_HYST_MV) begin
                        sup_q <= SUP_RISE;
                    end
                end
                SUP_RISE: begin
                    if (SUPPLY_MV < SUPPLY_TRIP_MV + SUPPLY_HYST_MV) begin
                        sup_q <= SUP_OFF;
                    end else if (filt_cnt_q == FC_W'(FILTER_CYCLES - 1)) begin
                        sup_q <= SUP_ON;
                        filt_cnt_q <= '0;
                    end else begin
                        filt_cnt_q <= filt_cnt_q + 1'b1;
                    end
                end
                SUP_ON: begin
                    filt_cnt_q <= '0;
                    if (SUPPLY_MV < SUPPLY_TRIP_MV) begin
                        sup_q <= SUP_FALL;
                    end
                end
                SUP_FALL: begin
                    if (SUPPLY_MV >= SUPPLY_TRIP_MV) begin
                        sup_q <= SUP_ON;
                    end else if (filt_cnt_q == FC_W'(FILTER_CYCLES - 1)) begin
                        sup_q <= SUP_OFF;
                        filt_cnt_q <= '0;
                    end else begin
                        filt_cnt_q <= filt_cnt_q + 1'b1;
                    end
                end
                default: begin
                    sup_q <= SUP_OFF;
                    filt_cnt_q <= '0;
                end
            endcase
        end
    end

    // a short dip during SUP_FALL keeps the block running; that is the filter
    assign supply_ok = (sup_q == SUP_ON) || (sup_q == SUP_FALL);
    assign active = supply_ok && ctrl_q[CTRL_EN_BIT];

    // select pins, or the register copy when software overrides them
    assign calib_scale_select = ctrl_q[CTRL_OVR_BIT] ? ctrl_q[CTRL_SCF_BIT] : CALIB_SCALE_SELECT;
    assign sel = ctrl_q[CTRL_OVR_BIT] ? {ctrl_q[CTRL_S1_BIT], ctrl_q[CTRL_S0_BIT]}
                                      : {RATE_SELECT_MSB, RATE_SELECT_LSB};
    assign e_shift = 6'(E_SHIFT_BASE) - {4'h0, sel};
    assign cf_shift = e_shift - {2'b00, cf_mult_log2(calib_scale_select, sel)};
    assign e_thr = ACC_W'(1) << e_shift;
    assign cf_thr = ACC_W'(1) << cf_shift;

    // the same high-pass on both channels keeps their phase equal at every
    // frequency, at the price of also dropping dc on the voltage side
    one_pole #(.W(SAMPLE_W), .SHIFT(HPF_SHIFT)) u_i_dc (
        .clk(CLK),
        .srst(SRST),
        .en(SAMPLE_VALID),
        .clr(!active),
        .x(CURRENT_CHANNEL),
        .y(i_lp)
    );
    one_pole #(.W(SAMPLE_W), .SHIFT(HPF_SHIFT)) u_v_dc (
        .clk(CLK),
        .srst(SRST),
        .en(SAMPLE_VALID),
        .clr(!active),
        .x(LINE_VOLTAGE_CHANNEL),
        .y(v_lp)
    );

    // high-pass is input minus its running mean; then multiply
    always_ff @(posedge CLK) begin
        if (SRST || !active) begin
            i_hp_q <= '0;
            v_hp_q <= '0;
            hp_vld_q <= 1'b0;
            prod_q <= '0;
            prod_vld_q <= 1'b0;
            pow_vld_q <= 1'b0;
        end else begin
            hp_vld_q <= SAMPLE_VALID;
            if (SAMPLE_VALID) begin
                i_hp_q <= CURRENT_CHANNEL - i_lp;
                v_hp_q <= LINE_VOLTAGE_CHANNEL - v_lp;
            end
            prod_vld_q <= hp_vld_q;
            if (hp_vld_q) begin
                prod_q <= PW'(i_hp_q) * PW'(v_hp_q);
            end
            pow_vld_q <= prod_vld_q;
        end
    end

    // corner sits near fs / (2*pi*2^LPF_SHIFT): 4.37 Hz class at 450 kHz
    one_pole #(.W(PW), .SHIFT(LPF_SHIFT)) u_power_lp (
        .clk(CLK),
        .srst(SRST),
        .en(prod_vld_q),
        .clr(!active),
        .x(prod_q),
        .y(power)
    );

    assign pow_mag = power[PW-1] ? PW'(-power) : PW'(power);
    assign e_sum = e_acc_q + ACC_W'(pow_mag);
    assign cf_sum = cf_acc_q + ACC_W'(pow_mag);
    assign e_fire = pow_vld_q && (e_sum >= e_thr);
    assign cf_fire = pow_vld_q && (cf_sum >= cf_thr);

    // digital-to-frequency: two accumulators, long one for energy, short for cal
    always_ff @(posedge CLK) begin
        if (SRST || !active) begin
            e_acc_q <= '0;
            cf_acc_q <= '0;
        end else if (pow_vld_q) begin
            e_acc_q <= e_fire ? e_sum - e_thr : e_sum;
            cf_acc_q <= cf_fire ? cf_sum - cf_thr : cf_sum;
        end
    end

    // pulse A on each energy step, then pulse B right after; a step that
    // lands while A is still low is dropped, so width must stay below period
    always_ff @(posedge CLK) begin
        if (SRST || !active) begin
            ea_cnt_q <= '0;
            eb_cnt_q <= '0;
            cf_cnt_q <= '0;
        end else begin
            if (e_fire && ea_cnt_q == '0) begin
                ea_cnt_q <= pulse_w_q;
            end else if (ea_cnt_q != '0) begin
                ea_cnt_q <= ea_cnt_q - 1'b1;
            end
            if (ea_cnt_q == 16'h0001) begin
                eb_cnt_q <= pulse_w_q;
            end else if (eb_cnt_q != '0) begin
                eb_cnt_q <= eb_cnt_q - 1'b1;
            end
            if (cf_fire && cf_cnt_q == '0) begin
                cf_cnt_q <= pulse_w_q;
            end else if (cf_cnt_q != '0) begin
                cf_cnt_q <= cf_cnt_q - 1'b1;
            end
        end
    end

    // reverse flag is resampled only at a calibration step, never latched
    always_ff @(posedge CLK) begin
        if (SRST || !active) begin
            reverse_power_flag_q <= 1'b0;
        end else if (cf_fire && cf_cnt_q == '0) begin
            reverse_power_flag_q <= power[PW-1];
        end
    end

    // outputs from flops; pulse pins idle high and the reverse flag low while inactive
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ENERGY_PULSE_A_N <= 1'b1;
            ENERGY_PULSE_B_N <= 1'b1;
            CALIB_PULSE_OUT_N <= 1'b1;
            REVERSE_POWER_FLAG <= 1'b0;
        end else begin
            ENERGY_PULSE_A_N <= !(active && ea_cnt_q != '0);
            ENERGY_PULSE_B_N <= !(active && eb_cnt_q != '0);
            CALIB_PULSE_OUT_N <= !(active && cf_cnt_q != '0);
            REVERSE_POWER_FLAG <= active && reverse_power_flag_q;
        end
    end

    // apb: zero wait, write in access phase, read data caught in setup
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_setup = PSEL && !PENABLE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign PSLVERR = slverr_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_q <= CTRL_RST;
            pulse_w_q <= 16'(PULSE_WIDTH);
        end else if (wr_en) begin
            if (PADDR == OFS_CTRL) begin
                ctrl_q <= PWDATA[4:0];
            end else if (PADDR == OFS_PULSE) begin
                pulse_w_q <= (PWDATA[15:0] == '0) ? 16'h0001 : PWDATA[15:0];
            end
        end
    end

    // pulse counter: a write clears it, a same-cycle pulse still counts
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cf_count_q <= '0;
        end else if (cf_fire && cf_cnt_q == '0) begin
            cf_count_q <= (wr_en && PADDR == OFS_CFCNT) ? 32'h0000_0001 : cf_count_q + 1'b1;
        end else if (wr_en && PADDR == OFS_CFCNT) begin
            cf_count_q <= '0;
        end
    end

    // read mux and error flag, both registered in the setup cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else if (rd_setup) begin
            slverr_q <= 1'b0;
            if (PADDR == OFS_CTRL) begin
                prdata_q <= {27'h000_0000, ctrl_q};
            end else if (PADDR == OFS_PULSE) begin
                prdata_q <= {16'h0000, pulse_w_q};
            end else if (PADDR == OFS_STATUS) begin
                prdata_q <= {29'h0000_0000, supply_ok, reverse_power_flag_q, active};
            end else if (PADDR == OFS_POWER) begin
                prdata_q <= 32'(power);
            end else if (PADDR == OFS_CFCNT) begin
                prdata_q <= cf_count_q;
            end else begin
                prdata_q <= '0;
                slverr_q <= 1'b1;
            end
        end
    end
endmodule // power_to_pulse_datapath

// ===== dv/p2p_checker.sv
// checker: timing of the pulse pins and the reverse flag against their causes
// assumes the datapath top ports only; bound to the design below the module
`timescale 1ns/1ps
module p2p_checker
    import p2p_pkg::*;
#(
    parameter int FILTER_CYCLES = 8,
    parameter int PULSE_WIDTH = 4
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SAMPLE_VALID,
    input wire logic [12:0] SUPPLY_MV,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic ENERGY_PULSE_A_N,
    input wire logic ENERGY_PULSE_B_N,
    input wire logic CALIB_PULSE_OUT_N,
    input wire logic REVERSE_POWER_FLAG
);
    logic [19:0] lo_q;
    logic [15:0] cf_len_q;
    logic [15:0] a_len_q;
    logic [15:0] b_len_q;
    logic en_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    // run lengths; lo_q saturates so a long brown-out never wraps to zero
    always_ff @(posedge CLK) begin
        if (SRST) begin
            lo_q <= 20'h0_0000;
        end else begin
            lo_q <= (SUPPLY_MV >= SUPPLY_TRIP_MV) ? 20'h0_0000 : lo_q + 20'(lo_q != 20'hF_FFFF);
        end
        cf_len_q <= CALIB_PULSE_OUT_N ? 16'h0000 : cf_len_q + 16'h0001;
        a_len_q <= ENERGY_PULSE_A_N ? 16'h0000 : a_len_q + 16'h0001;
        b_len_q <= ENERGY_PULSE_B_N ? 16'h0000 : b_len_q + 16'h0001;
    end
    // shadow of the enable bit; a software disable may cut a pulse or drop the flag
    always_ff @(posedge CLK) begin
        if (SRST) begin
            en_q <= CTRL_RST[CTRL_EN_BIT];
        end else if (PSEL && PENABLE && PWRITE && PADDR == OFS_CTRL) begin
            en_q <= PWDATA[CTRL_EN_BIT];
        end
    end
    property p_idle_low;
        lo_q >= 20'(FILTER_CYCLES + PULSE_WIDTH + 6)
            |-> ENERGY_PULSE_A_N && ENERGY_PULSE_B_N && CALIB_PULSE_OUT_N;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("pulse on low supply");
    property p_cf_width;
        $rose(CALIB_PULSE_OUT_N) && lo_q == 20'h0_0000 && en_q
            |-> cf_len_q == 16'(PULSE_WIDTH);
    endproperty
    a_cf_width: assert property (p_cf_width) else $error("calib pulse width");
    property p_a_width;
        $rose(ENERGY_PULSE_A_N) && lo_q == 20'h0_0000 && en_q
            |-> a_len_q == 16'(PULSE_WIDTH);
    endproperty
    a_a_width: assert property (p_a_width) else $error("energy a width");
    property p_b_width;
        $rose(ENERGY_PULSE_B_N) && lo_q == 20'h0_0000 && en_q
            |-> b_len_q == 16'(PULSE_WIDTH);
    endproperty
    a_b_width: assert property (p_b_width) else $error("energy b width");
    property p_b_after_a;
        $rose(ENERGY_PULSE_A_N) && lo_q == 20'h0_0000 && en_q
            |-> ##[0:1] $fell(ENERGY_PULSE_B_N);
    endproperty
    a_b_after_a: assert property (p_b_after_a) else $error("b not after a");
    property p_flag;
        $changed(REVERSE_POWER_FLAG) && lo_q == 20'h0_0000 && en_q
            |-> $fell(CALIB_PULSE_OUT_N);
    endproperty
    a_flag: assert property (p_flag) else $error("flag moved off calib pulse");
    property p_cf_src;
        $fell(CALIB_PULSE_OUT_N) |-> $past(SAMPLE_VALID, 5);
    endproperty
    a_cf_src: assert property (p_cf_src) else $error("calib pulse without sample");
    property p_a_src;
        $fell(ENERGY_PULSE_A_N) |-> $past(SAMPLE_VALID, 5);
    endproperty
    a_a_src: assert property (p_a_src) else $error("energy pulse without sample");
    c_cf: cover property ($fell(CALIB_PULSE_OUT_N));
    c_b: cover property ($fell(ENERGY_PULSE_B_N));
    c_rev: cover property ($rose(REVERSE_POWER_FLAG));
endmodule // p2p_checker

bind power_to_pulse_datapath p2p_checker #(
    .FILTER_CYCLES(FILTER_CYCLES),
    .PULSE_WIDTH(PULSE_WIDTH)
) p2p_checker_inst (
    .CLK(CLK),
    .SRST(SRST),
    .SAMPLE_VALID(SAMPLE_VALID),
    .SUPPLY_MV(SUPPLY_MV),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .ENERGY_PULSE_A_N(ENERGY_PULSE_A_N),
    .ENERGY_PULSE_B_N(ENERGY_PULSE_B_N),
    .CALIB_PULSE_OUT_N(CALIB_PULSE_OUT_N),
    .REVERSE_POWER_FLAG(REVERSE_POWER_FLAG)
);

// ===== dv/pulse_counter_model.sv
// host pulse counter: counts falling edges of each pulse pin inside a window
// assumes the host times the window itself; counts hold after it closes
`timescale 1ns/1ps
module pulse_counter_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic window_en,
    input wire logic cf_n,
    input wire logic a_n,
    input wire logic b_n,
    output logic [31:0] cf_count,
    output logic [31:0] a_count,
    output logic [31:0] b_count
);
    logic win_q, cf_q, a_q, b_q;
    // window far shorter than a real host uses; ripple is nil with steady power
    always_ff @(posedge clk) begin
        win_q <= window_en;
        cf_q <= cf_n;
        a_q <= a_n;
        b_q <= b_n;
        if (srst || (window_en && !win_q)) begin
            cf_count <= 32'h0000_0000;
            a_count <= 32'h0000_0000;
            b_count <= 32'h0000_0000;
        end else if (window_en) begin
            cf_count <= cf_count + 32'(cf_q && !cf_n);
            a_count <= a_count + 32'(a_q && !a_n);
            b_count <= b_count + 32'(b_q && !b_n);
        end
    end
endmodule // pulse_counter_model

// ===== dv/power_to_pulse_datapath_bench.sv
// bench: apb registers, supply levels, alternating samples and select pins
// assumes shortened filter and pulse counts; the host model counts pulses
`timescale 1ns/1ps
module power_to_pulse_datapath_bench;
    import p2p_pkg::*;
    localparam int FC = 8;
    localparam int PW = 4;
    localparam int EB = 32;
    logic clk, srst, psel, penable, pwrite, sv, calib_scale_select, s0, s1, win, ph, neg, pready, pslverr;
    logic a_n, b_n, cf_n, flag, err;
    logic [7:0] paddr;
    logic [12:0] sup;
    logic [31:0] pwdata, prdata, rd, cfc, ac, bc;
    logic signed [15:0] cur, vol;
    int failures, tests_run, cyc, iamp, vamp, dc, lg, sel;
    longint p, e;
    power_to_pulse_datapath #(.HPF_SHIFT(4), .LPF_SHIFT(4), .E_SHIFT_BASE(EB),
        .FILTER_CYCLES(FC), .PULSE_WIDTH(PW)) power_to_pulse_datapath_inst (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SAMPLE_VALID(sv), .CURRENT_CHANNEL(cur),
        .LINE_VOLTAGE_CHANNEL(vol), .SUPPLY_MV(sup), .CALIB_SCALE_SELECT(calib_scale_select),
        .RATE_SELECT_LSB(s0), .RATE_SELECT_MSB(s1), .ENERGY_PULSE_A_N(a_n),
        .ENERGY_PULSE_B_N(b_n), .CALIB_PULSE_OUT_N(cf_n), .REVERSE_POWER_FLAG(flag));
    pulse_counter_model pulse_counter_model_inst (.clk(clk), .srst(srst), .window_en(win),
        .cf_n(cf_n), .a_n(a_n), .b_n(b_n), .cf_count(cfc), .a_count(ac), .b_count(bc));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // sign flips every sample so the dc-removing filter passes it whole
    always @(posedge clk) begin
        ph <= ~ph;
        cur <= 16'(dc + (ph ? iamp : -iamp));
        vol <= (ph ^ neg) ? 16'(vamp) : 16'(-vamp);
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("FAIL %s exp %h got %h", w, x, g);
        end
    endtask
    task automatic near(input string w, input longint x, input longint t, input logic [31:0] g);
        tests_run++;
        if ($isunknown(g) || longint'(g) < x - t || longint'(g) > x + t) begin
            failures++;
            $display("FAIL %s exp %0d got %0d", w, x, g);
        end
    endtask
    // one transfer, entered just after an edge; held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so a following call never re-drives psel in this step
        @(posedge clk);
    endtask
    task automatic rx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk("register", x, rd & m);
    endtask
    task automatic run(input int n);
        win <= 1'b1;
        repeat (n) @(posedge clk);
        win <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        void'($urandom(13));
        {srst, sv, calib_scale_select} = 3'b111;
        {psel, penable, pwrite, s0, s1, win, ph, neg} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sup = 13'h0F3C;
        iamp = 4000;
        vamp = 4000;
        dc = 0;
        cyc = 0;
        failures = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rx(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
        rx(OFS_PULSE, 32'hFFFF_FFFF, PW);
        apb(1'b1, OFS_PULSE, 32'h0000_0000);
        rx(OFS_PULSE, 32'hFFFF_FFFF, 32'h0000_0001);
        apb(1'b1, OFS_PULSE, PW);
        apb(1'b1, OFS_STATUS, 32'h0000_0007);
        rx(OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], err});
        apb(1'b1, OFS_CTRL, 32'h0000_001D);
        rx(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_001D);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        run(300);
        near("cf idle", 0, 0, cfc);
        near("a idle", 0, 0, ac);
        sup <= 13'h1004;
        repeat (FC - 3) @(posedge clk);
        rx(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
        repeat (8) @(posedge clk);
        rx(OFS_STATUS, 32'h0000_0005, 32'h0000_0005);
        sup <= 13'h0FD2;
        repeat (20) @(posedge clk);
        sup <= 13'h0BB8;
        repeat (FC - 3) @(posedge clk);
        sup <= 13'h0FD2;
        repeat (20) @(posedge clk);
        rx(OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        // every select mode; amplitude set so calib pulses come about every 32 cycles
        for (int m = 0; m < 8; m++) begin
            sel = m % 4;
            lg = (m == 3) ? 11 : 7 - sel - (m < 4 ? 1 : 0);
            iamp <= int'($sqrt(2.0 ** (27 - sel - lg))) + $urandom_range(0, 7);
            vamp <= int'($sqrt(2.0 ** (27 - sel - lg))) + $urandom_range(0, 7);
            {calib_scale_select, s1, s0} <= m[2:0];
            neg <= (m % 2 == 0);
            repeat (300) @(posedge clk);
            apb(1'b0, OFS_POWER, 32'h0000_0000);
            chk("sign", {31'h0, neg}, {31'h0, rd[31]});
            p = longint'($signed(rd));
            p = (p < 0) ? -p : p;
            run(8192);
            e = 8192 * p;
            near("cf count", (e << lg) >> (EB - sel), ((e << lg) >> (EB - sel + 5)) + 2, cfc);
            near("a count", e >> (EB - sel), 1, ac);
            near("b count", e >> (EB - sel), 1, bc);
            chk("flag", {31'h0, neg}, {31'h0, flag});
        end
        iamp <= 0;
        dc <= 3000;
        repeat (600) @(posedge clk);
        apb(1'b0, OFS_POWER, 32'h0000_0000);
        chk("dc power", 32'h0000_0001, {31'h0, $signed(rd) < 4096 && $signed(rd) > -4096});
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        rx(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
        iamp <= 4000;
        dc <= 0;
        run(400);
        near("cf disabled", 0, 0, cfc);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        sup <= 13'h0F3C;
        repeat (FC + PW + 20) @(posedge clk);
        rx(OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
        chk("pins", 32'h0000_0007, {29'h0, a_n, b_n, cf_n});
        test_done();
    end
endmodule // power_to_pulse_datapath_bench
